// ==== hw/spi_cfg_pkg.sv ====
package spi_cfg_pkg;

    // ==========================================================
    // register offsets (byte addresses, one aligned word each)
    localparam logic [11:0] CFG_OFFSET = 12'h000;
    localparam logic [11:0] TX_OFFSET = 12'h004;
    localparam logic [11:0] RX_OFFSET = 12'h008;
    localparam logic [11:0] STATUS_OFFSET = 12'h00c;
    localparam logic [11:0] MODE_OFFSET = 12'h010;

    // ==========================================================
    // configuration register fields
    localparam int EN_BIT = 6;
    localparam int ODO_BIT = 5;
    localparam int ROLE_BIT = 4;
    localparam int CPOL_BIT = 3;
    localparam int CPHA_BIT = 2;
    localparam int LSBF_BIT = 1;
    localparam int XFER_MODE_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam logic [7:0] CFG_WMASK = 8'h7f;

    // ==========================================================
    // status register fields
    localparam int BUSY_BIT = 7;
    localparam int DONE_BIT = 0;

    // ==========================================================
    // mode selection register: stands for bits 5, 4 and 1 of the interrupt status register
    localparam int MODE_WIDTH = 3;
    localparam logic [MODE_WIDTH-1:0] MODE_RESET = 3'h0;
    localparam logic [MODE_WIDTH-1:0] MODE_DEFAULT = 3'h0;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCLK_HALF_NS = 100;
    localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BITS_PER_FRAME = 8;
    localparam logic [4:0] LAST_EDGE = 5'h0f;

    typedef enum logic [1:0] {
        m_idle,
        m_lead_in,
        m_clocking,
        m_lead_out
    } master_state_type;

endpackage

// ==== hw/spi_sync.sv ====
`timescale 1ns/10ps
module spi_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1) begin
            $error("spi_sync: WIDTH must be at least 1");
        end
    end

    // first stage feeds only the second one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else if (ce) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // spi_sync

// ==== hw/spi_clock_gen.sv ====
`timescale 1ns/10ps
module spi_clock_gen #(
    parameter int HALF_CYCLES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic run,
    output logic tick
);

    localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

    logic [CW-1:0] cnt_q;

    initial begin
        if (HALF_CYCLES < 1) begin
            $error("spi_clock_gen: HALF_CYCLES must be at least 1");
        end
    end

    // counter restarts whenever run drops, so every frame opens with a full half period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (ce) begin
            if (!run || cnt_q == LAST) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + CW'(1);
            end
            tick <= run && (cnt_q == LAST);
        end
    end

endmodule // spi_clock_gen

// ==== hw/spi_mode_config.sv ====
`timescale 1ns/10ps
module spi_mode_config
    import spi_cfg_pkg::*;
#(parameter int HALF_CYCLES = SCLK_HALF_CYCLES) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic ss_n_in,
    output logic ss_n_out,
    output logic ss_n_oe,
    output logic pullup_en,
    output logic [MODE_WIDTH-1:0] irq_mode
);

    initial begin
        if (HALF_CYCLES < 1) begin
            $error("spi_mode_config: HALF_CYCLES must be at least 1");
        end
    end

    // ==========================================================
    // register bus
    logic [7:0] cfg_q, tx_q, rx_q;
    logic [MODE_WIDTH-1:0] mode_q;
    logic [31:0] rdata_d;
    logic done_q, busy, err_d, setup, wr;
    assign setup = psel && !penable;
    assign wr = psel && penable && pready && pwrite;

    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr == CFG_OFFSET) begin
            rdata_d[7:0] = cfg_q;
        end else if (paddr == TX_OFFSET) begin
            rdata_d[7:0] = tx_q;
        end else if (paddr == RX_OFFSET) begin
            rdata_d[7:0] = rx_q;
        end else if (paddr == STATUS_OFFSET) begin
            rdata_d[BUSY_BIT] = busy;
            rdata_d[DONE_BIT] = done_q;
        end else if (paddr == MODE_OFFSET) begin
            rdata_d[MODE_WIDTH-1:0] = mode_q;
        end else begin
            err_d = 1'b1;
        end
    end

    // zero-wait slave: the answer is prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= setup;
            pslverr <= setup && err_d;
            if (setup && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end

    // ==========================================================
    // configuration
    logic en, odo, role, cpol, cpha, lsb_eff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= CFG_RESET;
            mode_q <= MODE_RESET;
        end else if (ce) begin
            if (wr && paddr == CFG_OFFSET) begin
                cfg_q <= pwdata[7:0] & CFG_WMASK;
            end
            if (wr && paddr == MODE_OFFSET) begin
                mode_q <= pwdata[MODE_WIDTH-1:0];
            end
        end
    end

    assign en = cfg_q[EN_BIT];
    assign odo = cfg_q[ODO_BIT];
    assign role = cfg_q[ROLE_BIT];
    assign cpol = cfg_q[CPOL_BIT];
    assign cpha = cfg_q[CPHA_BIT];
    assign lsb_eff = cfg_q[LSBF_BIT] && role;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mode <= MODE_DEFAULT;
        end else if (ce) begin
            irq_mode <= cfg_q[XFER_MODE_BIT] ? mode_q : MODE_DEFAULT;
        end
    end

    // ==========================================================
    // pin input synchronisers
    logic sclk_s, mosi_s, miso_s, ss_n_s;
    spi_sync #(.WIDTH(4), .RESET_VAL(4'h9)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in({ss_n_in, miso_in, mosi_in, sclk_in}),
        .sync_out({ss_n_s, miso_s, mosi_s, sclk_s})
    );

    // ==========================================================
    // master sequencer
    master_state_type mstate_q;
    logic [4:0] edge_cnt_q;
    logic sclk_q, ss_n_q, tick, start, m_lead, m_trail;
    assign start = wr && paddr == TX_OFFSET && en && role && mstate_q == m_idle;
    spi_clock_gen #(.HALF_CYCLES(HALF_CYCLES)) u_clock_gen (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .run(mstate_q != m_idle),
        .tick(tick)
    );
    assign m_lead = mstate_q == m_clocking && tick && !edge_cnt_q[0];
    assign m_trail = mstate_q == m_clocking && tick && edge_cnt_q[0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mstate_q <= m_idle;
            edge_cnt_q <= 5'h00;
            sclk_q <= 1'b0;
            ss_n_q <= 1'b1;
        end else if (ce) begin
            case (mstate_q)
                m_idle: begin
                    sclk_q <= cpol;
                    ss_n_q <= 1'b1;
                    edge_cnt_q <= 5'h00;
                    if (start) begin
                        mstate_q <= m_lead_in;
                        ss_n_q <= 1'b0;
                    end
                end
                m_lead_in: begin
                    if (tick) begin
                        mstate_q <= m_clocking;
                    end
                end
                m_clocking: begin
                    if (tick) begin
                        sclk_q <= !sclk_q;
                        edge_cnt_q <= edge_cnt_q + 5'h01;
                        if (edge_cnt_q == LAST_EDGE) begin
                            mstate_q <= m_lead_out;
                        end
                    end
                end
                m_lead_out: begin
                    if (tick) begin
                        mstate_q <= m_idle;
                        ss_n_q <= 1'b1;
                    end
                end
                default: begin
                    mstate_q <= m_idle;
                end
            endcase
            if (!en || !role) begin
                mstate_q <= m_idle;
                ss_n_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // slave edge detection
    logic sclk_prev_q, ss_prev_q, s_act, s_lead, s_trail, s_start;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // matches the synchroniser's reset level, so no false edge follows reset
            sclk_prev_q <= 1'b1;
            ss_prev_q <= 1'b1;
        end else if (ce) begin
            sclk_prev_q <= sclk_s;
            ss_prev_q <= ss_n_s;
        end
    end

    assign s_act = en && !role && !ss_n_s;
    assign s_lead = s_act && sclk_s != sclk_prev_q && sclk_prev_q == cpol;
    assign s_trail = s_act && sclk_s != sclk_prev_q && sclk_prev_q != cpol;
    assign s_start = s_act && ss_prev_q;

    // ==========================================================
    // shared data engine
    logic lead, trail, frame_start, din, sample, dout_q, done_ev;
    logic [2:0] bit_q;
    logic [7:0] rx_sh_q, rx_next;
    function automatic logic [2:0] bit_pos(input logic [2:0] k, input logic lsb);
        bit_pos = lsb ? k : 3'h7 - k;
    endfunction
    assign lead = role ? m_lead : s_lead;
    assign trail = role ? m_trail : s_trail;
    assign frame_start = role ? start : s_start;
    assign din = role ? miso_s : mosi_s;
    assign sample = cpha ? trail : lead;
    assign done_ev = sample && bit_q == 3'h7;
    assign busy = mstate_q != m_idle || s_act;
    always_comb begin
        rx_next = rx_sh_q;
        rx_next[bit_pos(bit_q, lsb_eff)] = din;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_q <= 8'h00;
            bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_q <= 8'h00;
            dout_q <= 1'b0;
        end else if (ce) begin
            // tx holds while a frame runs, so the byte on the wire cannot change mid-frame
            if (wr && paddr == TX_OFFSET && !busy) begin
                tx_q <= pwdata[7:0];
            end
            if (frame_start) begin
                bit_q <= 3'h0;
                if (!cpha) begin
                    dout_q <= role ? pwdata[bit_pos(3'h0, lsb_eff)] : tx_q[bit_pos(3'h0, lsb_eff)];
                end
            end else begin
                if (lead && cpha) begin
                    dout_q <= tx_q[bit_pos(bit_q, lsb_eff)];
                end
                if (trail && !cpha) begin
                    dout_q <= tx_q[bit_pos(bit_q + 3'h1, lsb_eff)];
                end
                if (sample) begin
                    rx_sh_q <= rx_next;
                end
                if (trail) begin
                    bit_q <= bit_q + 3'h1;
                end
                if (done_ev) begin
                    rx_q <= rx_next;
                end
            end
        end
    end

    // done flag: a completion in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else if (ce) begin
            if (done_ev) begin
                done_q <= 1'b1;
            end else if (wr && paddr == STATUS_OFFSET && pwdata[DONE_BIT]) begin
                done_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // pin drivers
    logic m_drive, s_drive;
    assign m_drive = en && role;
    assign s_drive = en && !role && !ss_n_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_out <= 1'b0;
            sclk_oe <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
            ss_n_out <= 1'b1;
            ss_n_oe <= 1'b0;
            pullup_en <= 1'b0;
        end else if (ce) begin
            // open drain only ever pulls low; a high level is left to the external pull-up
            sclk_out <= odo ? 1'b0 : sclk_q;
            sclk_oe <= m_drive && (!odo || !sclk_q);
            mosi_out <= odo ? 1'b0 : dout_q;
            mosi_oe <= m_drive && (!odo || !dout_q);
            miso_out <= odo ? 1'b0 : dout_q;
            miso_oe <= s_drive && (!odo || !dout_q);
            ss_n_out <= odo ? 1'b0 : ss_n_q;
            ss_n_oe <= m_drive && (!odo || !ss_n_q);
            pullup_en <= en && !odo;
        end
    end

endmodule // spi_mode_config

// ==== dv/spi_mode_config_checker.sv ====
`timescale 1ns/10ps
module spi_mode_config_checker
    import spi_cfg_pkg::*;
#(
    parameter int HALF_CYCLES = SCLK_HALF_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic ss_n_out,
    input wire logic ss_n_oe,
    input wire logic pullup_en,
    input wire logic [MODE_WIDTH-1:0] irq_mode
);
    // ==========================================================
    // shadow of the written settings; age_q saturates once outputs settle
    logic [7:0] cfg_q;
    logic [MODE_WIDTH-1:0] mode_q;
    logic [1:0] age_q;
    logic [4:0] edges_q;
    logic sclk_prev_q;
    // open drain only pulls low, so the released level is high
    wire logic sclk_lv = sclk_oe ? sclk_out : 1'b1;
    wire logic ss_lv = ss_n_oe ? ss_n_out : 1'b1;
    wire logic wr_done = psel && penable && pwrite && pready;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= 8'h01;
            mode_q <= '0;
            age_q <= 2'h3;
        end else if (wr_done && paddr == CFG_OFFSET) begin
            cfg_q <= pwdata[7:0] & 8'h7f;
            age_q <= 2'h0;
        end else if (wr_done && paddr == MODE_OFFSET) begin
            mode_q <= pwdata[MODE_WIDTH-1:0];
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edges_q <= 5'h00;
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_lv;
            edges_q <= ss_lv ? 5'h00 : edges_q + 5'(sclk_lv != sclk_prev_q);
        end
    end

    a_pullup_level: assert property (age_q == 2'h3 |-> pullup_en == (cfg_q[6] && !cfg_q[5]))
        else $error("pull-up enable does not follow the settings");
    a_idle_no_drive: assert property (!cfg_q[6] && age_q == 2'h3 |-> !(sclk_oe || mosi_oe || miso_oe || ss_n_oe))
        else $error("a pin is driven while the port is disabled");
    a_clock_by_master: assert property (sclk_oe && age_q == 2'h3 |-> cfg_q[6] && cfg_q[4])
        else $error("serial clock driven outside enabled master role");
    a_slave_miso_only: assert property (miso_oe && age_q == 2'h3 |-> cfg_q[6] && !cfg_q[4])
        else $error("slave data line driven outside enabled slave role");
    a_idle_clock_pol: assert property (ss_lv && cfg_q[6] && cfg_q[4] && age_q == 2'h3 |-> sclk_lv == cfg_q[3])
        else $error("serial clock idle level differs from polarity");
    a_edge_count: assert property ($rose(ss_lv) |-> edges_q == 5'h10)
        else $error("a frame did not carry sixteen clock edges");
    a_frame_span: assert property ($fell(ss_lv) |-> ##[62:74] $rose(ss_lv))
        else $error("frame length out of range");
    a_irq_mode_follow: assert property (age_q == 2'h3 |-> irq_mode == (cfg_q[0] ? mode_q : '0))
        else $error("mode output does not follow the selection");
endmodule // spi_mode_config_checker

bind spi_mode_config spi_mode_config_checker #(.HALF_CYCLES(HALF_CYCLES)) spi_mode_config_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_oe(mosi_oe),
    .miso_oe(miso_oe), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe), .pullup_en(pullup_en), .irq_mode(irq_mode));

// ==== dv/spi_far_device.sv ====
`timescale 1ns/10ps
module spi_far_device (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic ss_n,
    input wire logic cpha,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] sh = 8'h00;
    int n = 0;
    initial miso = 1'b0;
    initial got = 8'h00;
    always @(negedge ss_n) begin
        n = 0;
        sh = reply;
        if (!cpha) begin
            miso = sh[7];
            sh = sh << 1;
        end
    end
    always @(sclk) begin
        if (!ss_n) begin
            n = n + 1;
            if (n[0] != cpha) begin
                got = {got[6:0], mosi};
            end else begin
                miso = sh[7];
                sh = sh << 1;
            end
        end
    end
    // released line shows the inverse of its last value
    always @(posedge ss_n) miso = ~miso;
endmodule // spi_far_device

// ==== dv/spi_mode_config_tb_top.sv ====
`timescale 1ns/10ps
module spi_mode_config_tb_top
    import spi_cfg_pkg::*;
;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] exp; logic err;} row_type;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic pready, pslverr, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_n_out, ss_n_oe, pullup_en, e;
    logic [MODE_WIDTH-1:0] irq_mode;
    logic tb_sclk = 1'b1;
    logic tb_mosi = 1'b1;
    logic tb_ss_n = 1'b1;
    logic far_cpha = 1'b0;
    logic far_miso;
    logic [7:0] far_reply = 8'h00;
    logic [7:0] far_got, seen, tx;
    int num_errors = 0;
    int n_checks = 0;
    int ss_falls = 0;
    int t;
    wire logic sclk_w = sclk_oe ? sclk_out : tb_sclk;
    wire logic mosi_w = mosi_oe ? mosi_out : tb_mosi;
    wire logic ss_w = ss_n_oe ? ss_n_out : tb_ss_n;
    wire logic miso_w = miso_oe ? miso_out : far_miso;
    row_type rows [8] = '{'{1'b0, CFG_OFFSET, 32'h0, 32'h1, 1'b0}, '{1'b0, MODE_OFFSET, 32'h0, 32'h0, 1'b0},
        '{1'b1, MODE_OFFSET, 32'h5, 32'h0, 1'b0}, '{1'b0, MODE_OFFSET, 32'h0, 32'h5, 1'b0},
        '{1'b1, CFG_OFFSET, 32'hff, 32'h0, 1'b0}, '{1'b0, CFG_OFFSET, 32'h0, 32'h7f, 1'b0},
        '{1'b0, 12'h014, 32'h0, 32'h0, 1'b1}, '{1'b1, 12'h0fc, 32'hff, 32'h0, 1'b1}};

    always #12.5 pclk = ~pclk;
    always @(negedge ss_w) ss_falls++;

    spi_mode_config #(.HALF_CYCLES(4)) spi_mode_config_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
        .miso_oe(miso_oe), .ss_n_in(ss_w), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe), .pullup_en(pullup_en),
        .irq_mode(irq_mode));

    spi_far_device spi_far_device_inst (.sclk(sclk_w), .mosi(mosi_w), .ss_n(ss_w), .cpha(far_cpha),
        .reply(far_reply), .miso(far_miso), .got(far_got));

    // ==========================================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
        n_checks++;
        if (seen_v !== exp_v) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp_v, seen_v);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic er);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int k = 0; k < 8; k++) rev8[k] = v[7 - k];
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #500000;
        num_errors++;
        give_verdict();
    end

    // ==========================================================
    // tests
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        ss_falls = 0;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, r, e);
            chk("prdata", rows[i].w ? 32'h0 : r, rows[i].exp);
            chk("pslverr", {31'h0, e}, {31'h0, rows[i].err});
        end
        chk("pullup_en", {31'h0, pullup_en}, 32'h0);
        $display("test register rows done");
        apb(1'b1, CFG_OFFSET, 32'h41, r, e);
        @(posedge pclk);
        chk("pullup_en", {31'h0, pullup_en}, 32'h1);
        chk("irq_mode", {29'h0, irq_mode}, 32'h5);
        apb(1'b1, CFG_OFFSET, 32'h10, r, e);
        apb(1'b1, TX_OFFSET, 32'ha5, r, e);
        repeat (100) @(posedge pclk);
        chk("irq_mode", {29'h0, irq_mode}, 32'h0);
        chk("ss falls", ss_falls, 32'h0);
        $display("test disabled port done");
        for (int i = 0; i < 8; i++) begin
            tx = 8'ha1 + 8'(i);
            far_cpha <= i[1];
            far_reply <= 8'h3c ^ 8'(i);
            apb(1'b1, CFG_OFFSET, {24'h0, 8'h51 | 8'(i << 1) | (i == 7 ? 8'h20 : 8'h00)}, r, e);
            apb(1'b1, TX_OFFSET, {24'h0, tx}, r, e);
            t = 0;
            do begin
                apb(1'b0, STATUS_OFFSET, 32'h0, r, e);
                t++;
            end while (!(r[DONE_BIT] === 1'b1 && r[BUSY_BIT] === 1'b0) && t < 80);
            chk("status", {30'h0, r[BUSY_BIT], r[DONE_BIT]}, 32'h1);
            apb(1'b0, RX_OFFSET, 32'h0, r, e);
            chk("far byte", {24'h0, far_got}, {24'h0, i[0] ? rev8(tx) : tx});
            chk("rx byte", r, {24'h0, i[0] ? rev8(8'h3c ^ 8'(i)) : 8'h3c ^ 8'(i)});
            apb(1'b1, STATUS_OFFSET, 32'h1, r, e);
        end
        chk("frames", ss_falls, 32'h8);
        $display("test master frames done");
        apb(1'b1, CFG_OFFSET, 32'h41, r, e);
        tb_sclk <= 1'b0;
        apb(1'b1, TX_OFFSET, 32'h96, r, e);
        tx = 8'h5a;
        tb_ss_n <= 1'b0;
        repeat (4) @(posedge pclk);
        for (int b = 7; b >= 0; b--) begin
            tb_mosi <= tx[b];
            repeat (4) @(posedge pclk);
            tb_sclk <= 1'b1;
            repeat (2) @(posedge pclk);
            seen[b] = miso_w;
            repeat (2) @(posedge pclk);
            tb_sclk <= 1'b0;
        end
        repeat (4) @(posedge pclk);
        tb_ss_n <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b0, RX_OFFSET, 32'h0, r, e);
        chk("slave rx", r, 32'h5a);
        chk("slave miso", {24'h0, seen}, 32'h96);
        $display("test slave frame done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("pullup_en in reset", {31'h0, pullup_en}, 32'h0);
        chk("irq_mode in reset", {29'h0, irq_mode}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, CFG_OFFSET, 32'h0, r, e);
        chk("cfg after reset", r, {24'h0, CFG_RESET});
        apb(1'b0, MODE_OFFSET, 32'h0, r, e);
        chk("mode after reset", r, 32'h0);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule // spi_mode_config_tb_top
